// ### ocf_top.sv
// counter overflow flag registers behind an axi4-lite slave
`timescale 1ns/1ns
`default_nettype none

module ocf_top (
  input  wire logic                        CLK,
  input  wire logic                        RESET_N,
  input  wire ocf_pkg::ocf_wrap_t          WRAP,
  input  wire logic [ocf_pkg::ADDR_W-1:0]  S_AXI_AWADDR,
  input  wire logic [2:0]                  S_AXI_AWPROT,
  input  wire logic                        S_AXI_AWVALID,
  output logic                             S_AXI_AWREADY,
  input  wire logic [31:0]                 S_AXI_WDATA,
  input  wire logic [3:0]                  S_AXI_WSTRB,
  input  wire logic                        S_AXI_WVALID,
  output logic                             S_AXI_WREADY,
  output logic [1:0]                       S_AXI_BRESP,
  output logic                             S_AXI_BVALID,
  input  wire logic                        S_AXI_BREADY,
  input  wire logic [ocf_pkg::ADDR_W-1:0]  S_AXI_ARADDR,
  input  wire logic [2:0]                  S_AXI_ARPROT,
  input  wire logic                        S_AXI_ARVALID,
  output logic                             S_AXI_ARREADY,
  output logic [31:0]                      S_AXI_RDATA,
  output logic [1:0]                       S_AXI_RRESP,
  output logic                             S_AXI_RVALID,
  input  wire logic                        S_AXI_RREADY,
  output logic                             IRQ
);

  // ****************************************************************
  // bus state
  // ****************************************************************
  typedef struct packed {
    logic                      aw_got;
    logic                      w_got;
    logic [ocf_pkg::IDX_W-1:0] w_idx;
    logic [2:0]                w_low;
    logic                      w_strb0;
    logic                      bvalid;
    logic [1:0]                bresp;
    logic                      rvalid;
    logic [1:0]                rresp;
    logic [31:0]               rdata;
  } ocf_bus_st_t;

  ocf_bus_st_t                st_r;
  ocf_bus_st_t                st_nxt;

  logic                       aw_fire;
  logic                       w_fire;
  logic                       wr_done;
  logic [ocf_pkg::IDX_W-1:0]  wr_idx;
  logic [2:0]                 wr_low;
  logic                       wr_strb0;
  logic                       wr_ok;
  logic                       mask_we;
  logic                       rd_fire;
  logic [ocf_pkg::IDX_W-1:0]  rd_idx;
  logic [31:0]                rd_word;
  logic [1:0]                 rd_resp;
  logic                       clr_txp;
  logic                       clr_txl;
  logic                       clr_err;
  logic                       clr_stat;

  logic [ocf_pkg::PORTS-1:0]  txp_set;
  logic [ocf_pkg::PORTS-1:0]  txl_set;
  logic [ocf_pkg::PORTS-1:0]  err_set;
  logic [ocf_pkg::PORTS-1:0]  txp_flags;
  logic [ocf_pkg::PORTS-1:0]  txl_flags;
  logic [ocf_pkg::PORTS-1:0]  err_flags;
  logic [2:0]                 irq_ev;
  logic [2:0]                 irq_stat;
  logic [2:0]                 irq_mask;

  assign txp_set = WRAP.tx_pkt;
  assign txl_set = WRAP.tx_len;
  assign err_set = WRAP.err;

  // ****************************************************************
  // write channel
  // ****************************************************************
  // address and data are taken independently; the response waits for both
  assign S_AXI_AWREADY = ~st_r.aw_got & ~st_r.bvalid;
  assign S_AXI_WREADY  = ~st_r.w_got & ~st_r.bvalid;
  assign aw_fire       = S_AXI_AWVALID & S_AXI_AWREADY;
  assign w_fire        = S_AXI_WVALID & S_AXI_WREADY;
  assign wr_done       = (st_r.aw_got | aw_fire) & (st_r.w_got | w_fire) & ~st_r.bvalid;
  assign wr_idx        = st_r.aw_got ? st_r.w_idx : S_AXI_AWADDR[ocf_pkg::ADDR_W-1:2];
  assign wr_low        = st_r.w_got ? st_r.w_low : S_AXI_WDATA[2:0];
  assign wr_strb0      = st_r.w_got ? st_r.w_strb0 : S_AXI_WSTRB[0];

  // flag registers are read-only; a write to them is accepted and dropped
  always_comb begin
    unique case (wr_idx)
      ocf_pkg::IDX_TXP,
      ocf_pkg::IDX_TXL,
      ocf_pkg::IDX_ERR,
      ocf_pkg::IDX_IRQ_STAT,
      ocf_pkg::IDX_IRQ_MASK: wr_ok = 1'b1;
      default:               wr_ok = 1'b0;
    endcase
  end

  assign mask_we = wr_done & wr_strb0 & (wr_idx == ocf_pkg::IDX_IRQ_MASK);

  // ****************************************************************
  // read channel
  // ****************************************************************
  // one read in flight; the next address is held off until rdata is taken
  assign S_AXI_ARREADY = ~st_r.rvalid;
  assign rd_fire       = S_AXI_ARVALID & S_AXI_ARREADY;
  assign rd_idx        = S_AXI_ARADDR[ocf_pkg::ADDR_W-1:2];

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_resp = ocf_pkg::RESP_OKAY;
    case (rd_idx)
      ocf_pkg::IDX_TXP:      rd_word = 32'(txp_flags);
      ocf_pkg::IDX_TXL:      rd_word = 32'(txl_flags);
      ocf_pkg::IDX_ERR:      rd_word = 32'(err_flags);
      ocf_pkg::IDX_IRQ_STAT: rd_word = 32'(irq_stat);
      ocf_pkg::IDX_IRQ_MASK: rd_word = 32'(irq_mask);
      default:               rd_resp = ocf_pkg::RESP_SLVERR;
    endcase
  end

  // the clear lands on the same edge that captures rdata
  assign clr_txp  = rd_fire & (rd_idx == ocf_pkg::IDX_TXP);
  assign clr_txl  = rd_fire & (rd_idx == ocf_pkg::IDX_TXL);
  assign clr_err  = rd_fire & (rd_idx == ocf_pkg::IDX_ERR);
  assign clr_stat = rd_fire & (rd_idx == ocf_pkg::IDX_IRQ_STAT);

  // ****************************************************************
  // state update
  // ****************************************************************
  always_comb begin
    st_nxt = st_r;
    if (aw_fire) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.w_idx  = S_AXI_AWADDR[ocf_pkg::ADDR_W-1:2];
    end
    if (w_fire) begin
      st_nxt.w_got   = 1'b1;
      st_nxt.w_low   = S_AXI_WDATA[2:0];
      st_nxt.w_strb0 = S_AXI_WSTRB[0];
    end
    if (wr_done) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got  = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp  = wr_ok ? ocf_pkg::RESP_OKAY : ocf_pkg::RESP_SLVERR;
    end else if (st_r.bvalid && S_AXI_BREADY) begin
      st_nxt.bvalid = 1'b0;
    end
    if (rd_fire) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata  = rd_word;
      st_nxt.rresp  = rd_resp;
    end else if (st_r.rvalid && S_AXI_RREADY) begin
      st_nxt.rvalid = 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign S_AXI_BVALID = st_r.bvalid;
  assign S_AXI_BRESP  = st_r.bresp;
  assign S_AXI_RVALID = st_r.rvalid;
  assign S_AXI_RDATA  = st_r.rdata;
  assign S_AXI_RRESP  = st_r.rresp;

  // ****************************************************************
  // flag registers and interrupt
  // ****************************************************************
  ocf_flag_bank #(.PORTS(ocf_pkg::PORTS)) u_txp (
    .clk   (CLK),
    .rst_n (RESET_N),
    .set   (txp_set),
    .clr   (clr_txp),
    .flags (txp_flags)
  );

  ocf_flag_bank #(.PORTS(ocf_pkg::PORTS)) u_txl (
    .clk   (CLK),
    .rst_n (RESET_N),
    .set   (txl_set),
    .clr   (clr_txl),
    .flags (txl_flags)
  );

  ocf_flag_bank #(.PORTS(ocf_pkg::PORTS)) u_err (
    .clk   (CLK),
    .rst_n (RESET_N),
    .set   (err_set),
    .clr   (clr_err),
    .flags (err_flags)
  );

  // any wrap in a group raises that group's interrupt event
  assign irq_ev[ocf_pkg::EV_TXP] = |txp_set;
  assign irq_ev[ocf_pkg::EV_TXL] = |txl_set;
  assign irq_ev[ocf_pkg::EV_ERR] = |err_set;

  ocf_irq u_irq (
    .clk        (CLK),
    .rst_n      (RESET_N),
    .ev         (irq_ev),
    .stat_clr   (clr_stat),
    .mask_we    (mask_we),
    .mask_wdata (wr_low),
    .status     (irq_stat),
    .mask       (irq_mask),
    .irq        (IRQ)
  );

  // ****************************************************************
  // checks
  // ****************************************************************
  txl_map_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    (rd_fire && rd_idx == ocf_pkg::IDX_TXL)
      |=> (S_AXI_RVALID && S_AXI_RDATA == 32'($past(txl_flags))))
    else $error("tx length flags read back wrong");

  txl_set_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    (txl_set != '0) |=> ((txl_flags & $past(txl_set)) == $past(txl_set)))
    else $error("tx length wrap did not set its flag");

  txl_clear_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    (clr_txl && txl_set == '0) |=> (txl_flags == '0))
    else $error("tx length flags not cleared by read");

  err_map_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    (rd_fire && rd_idx == ocf_pkg::IDX_ERR)
      |=> (S_AXI_RVALID && S_AXI_RDATA[25:0] == $past(err_flags)
           && S_AXI_RDATA[31:26] == '0))
    else $error("error flags read back wrong");

  err_flag_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    (clr_err && err_set == '0) ##1 (err_set == '0) |=> (err_flags == '0))
    else $error("error flags reappeared without a wrap");

  txp_high_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    (txp_set[25:19] != '0) |=> (txp_flags[25:19] != '0)
      ##0 ((txp_flags & $past(txp_set)) == $past(txp_set)))
    else $error("high port packet wrap lost");

  reset_zero_a: assert property (@(posedge CLK)
    $rose(RESET_N) |-> (txp_flags == '0 && txl_flags == '0 && err_flags == '0))
    else $error("flags not zero after reset");

  txp_clear_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    (clr_txp && txp_set == '0) |=> (txp_flags == '0) [*1] ##0 !S_AXI_ARREADY)
    else $error("tx packet flags not cleared by read");

  set_wins_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    (clr_txl || clr_err || clr_txp)
      |=> ((txl_flags & $past(txl_set)) == $past(txl_set)
           && (err_flags & $past(err_set)) == $past(err_set)
           && (txp_flags & $past(txp_set)) == $past(txp_set)))
    else $error("wrap lost in clearing read cycle");

  irq_level_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    IRQ == |(irq_stat & irq_mask))
    else $error("interrupt level disagrees with status and mask");

  bresp_map_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    wr_done |=> (S_AXI_BVALID && (S_AXI_BRESP == ocf_pkg::RESP_OKAY) == $past(wr_ok)))
    else $error("write response wrong");

endmodule : ocf_top
`default_nettype wire

// ### ocf_pkg.sv
// shared constants and types for the per-port counter overflow flag bank
package ocf_pkg;

  // ****************************************************************
  // geometry
  // ****************************************************************
  localparam int PORTS  = 26;
  localparam int ADDR_W = 8;
  localparam int IDX_W  = 6;

  // ****************************************************************
  // register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [IDX_W-1:0] IDX_TXP      = 6'h10;
  localparam logic [IDX_W-1:0] IDX_TXL      = 6'h11;
  localparam logic [IDX_W-1:0] IDX_ERR      = 6'h12;
  localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 6'h20;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 6'h21;

  // ****************************************************************
  // reset values and field positions
  // ****************************************************************
  localparam logic [PORTS-1:0] FLAG_RST     = 26'h000_0000;
  localparam logic [2:0]       IRQ_STAT_RST = 3'h0;
  localparam logic [2:0]       IRQ_MASK_RST = 3'h0;
  localparam int               EV_TXP       = 0;
  localparam int               EV_TXL       = 1;
  localparam int               EV_ERR       = 2;

  // ****************************************************************
  // bus responses
  // ****************************************************************
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // per-port wrap strobes from the statistics counters
  typedef struct packed {
    logic [PORTS-1:0] tx_pkt;
    logic [PORTS-1:0] tx_len;
    logic [PORTS-1:0] err;
  } ocf_wrap_t;

endpackage : ocf_pkg

// ### ocf_flag_bank.sv
// one register of sticky per-port overflow flags, cleared by a read
`timescale 1ns/1ns
`default_nettype none
module ocf_flag_bank #(
  parameter int PORTS = ocf_pkg::PORTS
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [PORTS-1:0] set,
  input  wire logic             clr,
  output logic      [PORTS-1:0] flags
);

  typedef struct packed {
    logic [PORTS-1:0] flags;
  } ocf_bank_st_t;

  ocf_bank_st_t     st_r;
  ocf_bank_st_t     st_nxt;
  logic [PORTS-1:0] bit_nxt;

  // set beats the read clear so a wrap in the read cycle survives
  for (genvar i = 0; i < PORTS; i++) begin : g_bit
    assign bit_nxt[i] = set[i] | (st_r.flags[i] & ~clr);
  end

  always_comb begin
    st_nxt       = st_r;
    st_nxt.flags = bit_nxt;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r.flags <= PORTS'(ocf_pkg::FLAG_RST);
    end else begin
      st_r <= st_nxt;
    end
  end

  assign flags = st_r.flags;

endmodule : ocf_flag_bank
`default_nettype wire

// ### ocf_irq.sv
// sticky interrupt status with mask and one level output
`timescale 1ns/1ns
`default_nettype none
module ocf_irq (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [2:0] ev,
  input  wire logic       stat_clr,
  input  wire logic       mask_we,
  input  wire logic [2:0] mask_wdata,
  output logic      [2:0] status,
  output logic      [2:0] mask,
  output logic            irq
);

  typedef struct packed {
    logic [2:0] status;
    logic [2:0] mask;
  } ocf_irq_st_t;

  ocf_irq_st_t st_r;
  ocf_irq_st_t st_nxt;

  always_comb begin
    st_nxt        = st_r;
    // an event in the clearing read cycle stays pending
    st_nxt.status = ev | (st_r.status & ~{3{stat_clr}});
    if (mask_we) begin
      st_nxt.mask = mask_wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r.status <= ocf_pkg::IRQ_STAT_RST;
      st_r.mask   <= ocf_pkg::IRQ_MASK_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign status = st_r.status;
  assign mask   = st_r.mask;
  assign irq    = |(st_r.status & st_r.mask);

endmodule : ocf_irq
`default_nettype wire

// ### port_counter_overflow_flags_tb.sv
// self-checking testbench for the counter overflow flag registers
`timescale 1ns/1ns
`default_nettype none
module port_counter_overflow_flags_tb;
  logic               clk;
  logic               reset_n;
  ocf_pkg::ocf_wrap_t wrap;
  logic [7:0]         awaddr;
  logic [7:0]         araddr;
  logic [31:0]        wdata;
  logic [31:0]        rdata;
  logic [1:0]         bresp;
  logic [1:0]         rresp;
  logic               awvalid, awready, wvalid, wready, bvalid, bready;
  logic               arvalid, arready, rvalid, rready, irq;
  int                 mismatches;
  int                 n_tests;

  ocf_top uut (
    .CLK(clk), .RESET_N(reset_n), .WRAP(wrap),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWPROT(3'h0), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARPROT(3'h0), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .IRQ(irq)
  );

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : report_and_stop

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // ready and valid are sampled at the falling edge: they only move on rising edges
  task automatic bus_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int   n;
    logic got;
    logic take;
    n = 0;
    got = 1'b0;
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!got && n < 100) begin
      @(negedge clk);
      take = arvalid && arready;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        got = 1'b1;
      end
      @(posedge clk);
      if (take) arvalid <= 1'b0;
      n++;
    end
    rready <= 1'b0;
    if (!got) begin
      mismatches++;
      $display("ERROR read response expected 1 seen 0");
      report_and_stop;
    end
  endtask : bus_read

  task automatic bus_write(input logic [7:0] a, input logic [31:0] dt, output logic [1:0] r);
    int   n;
    logic got;
    logic ta;
    logic tw;
    n = 0;
    got = 1'b0;
    @(posedge clk);
    awaddr  <= a;
    wdata   <= dt;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!got && n < 100) begin
      @(negedge clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      if (bvalid) begin
        r = bresp;
        got = 1'b1;
      end
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      n++;
    end
    bready <= 1'b0;
    if (!got) begin
      mismatches++;
      $display("ERROR write response expected 1 seen 0");
      report_and_stop;
    end
  endtask : bus_write

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp,
                        input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    bus_read(a, d, r);
    check(nm, d, exp);
    check({nm, " resp"}, {30'h0, r}, {30'h0, er});
  endtask : rd_chk

  function automatic logic [7:0] flag_addr(input int g);
    case (g)
      0:       flag_addr = {ocf_pkg::IDX_TXP, 2'b00};
      1:       flag_addr = {ocf_pkg::IDX_TXL, 2'b00};
      default: flag_addr = {ocf_pkg::IDX_ERR, 2'b00};
    endcase
  endfunction : flag_addr

  function automatic ocf_pkg::ocf_wrap_t mk(input int g, input int p);
    mk = '0;
    case (g)
      0:       mk.tx_pkt[p] = 1'b1;
      1:       mk.tx_len[p] = 1'b1;
      default: mk.err[p] = 1'b1;
    endcase
  endfunction : mk

  task automatic pulse(input ocf_pkg::ocf_wrap_t v);
    @(posedge clk);
    wrap <= v;
    @(posedge clk);
    wrap <= '0;
  endtask : pulse

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset;
    check("irq", {31'h0, irq}, 32'h0000_0000);
    for (int g = 0; g < 3; g++) rd_chk("flags", flag_addr(g), 32'h0000_0000, 2'h0);
    rd_chk("status", {ocf_pkg::IDX_IRQ_STAT, 2'b00}, 32'h0000_0000, 2'h0);
    rd_chk("mask", {ocf_pkg::IDX_IRQ_MASK, 2'b00}, 32'h0000_0000, 2'h0);
  endtask : t_reset

  // every port of every group, other groups must stay clear
  task automatic t_map;
    for (int g = 0; g < 3; g++) begin
      for (int p = 0; p < ocf_pkg::PORTS; p++) begin
        pulse(mk(g, p));
        for (int h = 0; h < 3; h++)
          rd_chk("map", flag_addr(h), (h == g) ? (32'h1 << p) : 32'h0, 2'h0);
        rd_chk("cleared", flag_addr(g), 32'h0000_0000, 2'h0);
      end
    end
    rd_chk("status all", {ocf_pkg::IDX_IRQ_STAT, 2'b00}, 32'h0000_0007, 2'h0);
  endtask : t_map

  // wrap held high across the clearing read must survive it
  task automatic t_hold;
    for (int g = 0; g < 3; g++) begin
      @(posedge clk);
      wrap <= mk(g, 5);
      rd_chk("hold first", flag_addr(g), 32'h0000_0020, 2'h0);
      wrap <= '0;
      rd_chk("hold kept", flag_addr(g), 32'h0000_0020, 2'h0);
      rd_chk("hold gone", flag_addr(g), 32'h0000_0000, 2'h0);
    end
    rd_chk("status hold", {ocf_pkg::IDX_IRQ_STAT, 2'b00}, 32'h0000_0007, 2'h0);
  endtask : t_hold

  task automatic t_irq;
    logic [1:0] r;
    bus_write({ocf_pkg::IDX_IRQ_MASK, 2'b00}, 32'h1 << ocf_pkg::EV_TXL, r);
    check("mask wr resp", {30'h0, r}, 32'h0000_0000);
    rd_chk("mask rd", {ocf_pkg::IDX_IRQ_MASK, 2'b00}, 32'h1 << ocf_pkg::EV_TXL, 2'h0);
    pulse(mk(2, 3));
    @(negedge clk);
    check("irq masked", {31'h0, irq}, 32'h0000_0000);
    rd_chk("status err", {ocf_pkg::IDX_IRQ_STAT, 2'b00}, 32'h1 << ocf_pkg::EV_ERR, 2'h0);
    rd_chk("err flag", flag_addr(2), 32'h0000_0008, 2'h0);
    pulse(mk(1, 25));
    @(negedge clk);
    check("irq raised", {31'h0, irq}, 32'h0000_0001);
    rd_chk("status txl", {ocf_pkg::IDX_IRQ_STAT, 2'b00}, 32'h1 << ocf_pkg::EV_TXL, 2'h0);
    @(negedge clk);
    check("irq cleared", {31'h0, irq}, 32'h0000_0000);
    rd_chk("txl flag", flag_addr(1), 32'h0200_0000, 2'h0);
  endtask : t_irq

  // unmapped places answer with an error, flag registers ignore writes
  task automatic t_err;
    logic [1:0] r;
    rd_chk("unmapped rd", 8'h4C, 32'h0000_0000, ocf_pkg::RESP_SLVERR);
    bus_write(8'hFC, 32'hFFFF_FFFF, r);
    check("unmapped wr", {30'h0, r}, {30'h0, ocf_pkg::RESP_SLVERR});
    bus_write(flag_addr(1), 32'hFFFF_FFFF, r);
    check("ro wr resp", {30'h0, r}, {30'h0, ocf_pkg::RESP_OKAY});
    rd_chk("ro unchanged", flag_addr(1), 32'h0000_0000, 2'h0);
  endtask : t_err

  // a second reset in mid-run wipes pending flags
  task automatic t_rst2;
    pulse(mk(0, 19));
    pulse(mk(2, 0));
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    t_reset;
  endtask : t_rst2

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    reset_n = 1'b0;
    wrap = '0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0000_0000;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    mismatches = 0;
    n_tests = 0;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    t_reset;
    t_map;
    t_hold;
    t_irq;
    t_err;
    t_rst2;
    report_and_stop;
  end
endmodule : port_counter_overflow_flags_tb
`default_nettype wire
